// >>> rtl/utd_pkg.sv
// shared constants for the transmit descriptor dma engine and its memory/fifo partner
package utd_pkg;
  localparam int unsigned UTD_AW = 32;
  localparam int unsigned UTD_DW = 32;
  localparam int unsigned UTD_BW = 8;
  localparam int unsigned UTD_LW = 16;
  // descriptor layout, four words, 16-byte aligned
  localparam logic [31:0] UTD_DESC_BYTES = 32'h0000_0010;
  localparam logic [31:0] UTD_W0_OFF = 32'h0000_0000;
  localparam logic [31:0] UTD_W3_OFF = 32'h0000_000C;
  localparam logic [1:0] UTD_LAST_WORD = 2'h3;
  localparam int unsigned UTD_FIRST_BIT = 31;
  localparam int unsigned UTD_LAST_BIT = 30;
  localparam int unsigned UTD_OWN_BIT = 29;
  localparam int unsigned UTD_DRAIN_BIT = 28;
  localparam int unsigned UTD_ZERO_BIT = 23;
  localparam int unsigned UTD_OFS_LSB = 16;
  localparam logic [31:0] UTD_CTL_MASK = 32'hF080_FFFF;
  localparam logic [31:0] UTD_NULL = 32'h0000_0000;
  // partner user-port map
  localparam int unsigned UTD_MEM_WORDS = 256;
  localparam int unsigned UTD_MEM_IW = 8;
  localparam logic [31:0] UTD_ADR_HEAD = 32'h0000_0400;
  localparam logic [31:0] UTD_ADR_COMP = 32'h0000_0404;
  localparam logic [31:0] UTD_ADR_STAT = 32'h0000_0408;
  localparam logic [31:0] UTD_ADR_MEM_TOP = 32'h0000_0400;
endpackage

// >>> rtl/utd_if.sv
// link between the dma engine and its memory, software and endpoint fifo partner
`timescale 1ns/100ps
`default_nettype none
interface utd_if;
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic reg_wr;
  logic reg_sel_comp;
  logic [31:0] reg_wdata;
  logic [31:0] tx_queue_head_ptr;
  logic [31:0] tx_completion_ptr;
  logic chan_irq;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_zero;
  logic tx_ready;
  modport engine (output mem_req, mem_we, mem_addr, mem_wdata, input mem_ack, mem_rdata,
    input reg_wr, reg_sel_comp, reg_wdata, output tx_queue_head_ptr, tx_completion_ptr, chan_irq,
    output tx_valid, tx_data, tx_last, tx_zero, input tx_ready);
  modport partner (input mem_req, mem_we, mem_addr, mem_wdata, output mem_ack, mem_rdata,
    output reg_wr, reg_sel_comp, reg_wdata, input tx_queue_head_ptr, tx_completion_ptr, chan_irq,
    input tx_valid, tx_data, tx_last, tx_zero, output tx_ready);
endinterface
`default_nettype wire

// >>> rtl/utd_partner.sv
// memory, software port and endpoint fifo sink facing the dma engine
`timescale 1ns/100ps
`default_nettype none
module utd_partner
  import utd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  utd_if.partner lnk,
  input wire logic [31:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic ep_valid,
  output logic [7:0] ep_data,
  output logic ep_last,
  output logic ep_zero,
  input wire logic ep_take
);
  logic [31:0] mem_q [UTD_MEM_WORDS];
  logic ack_q;
  logic [31:0] rdata_q;
  logic reg_wr_q;
  logic reg_sel_q;
  logic [31:0] reg_wdata_q;
  logic [UTD_MEM_IW-1:0] sw_idx;
  logic [UTD_MEM_IW-1:0] ln_idx;

  assign sw_idx = sw_addr[UTD_MEM_IW+1:2];
  assign ln_idx = lnk.mem_addr[UTD_MEM_IW+1:2];
  assign lnk.mem_ack = ack_q;
  assign lnk.mem_rdata = rdata_q;
  assign lnk.reg_wr = reg_wr_q;
  assign lnk.reg_sel_comp = reg_sel_q;
  assign lnk.reg_wdata = reg_wdata_q;
  // accept a byte only while the holding slot is free, so back-pressure reaches the engine
  assign lnk.tx_ready = ~ep_valid;

  // software builds descriptor queues here; engine write wins a same-word collision
  always_ff @(posedge clock)
  begin
    if (sw_wr && sw_addr < UTD_ADR_MEM_TOP)
      mem_q[sw_idx] <= sw_wdata;
    if (lnk.mem_req && lnk.mem_we)
      mem_q[ln_idx] <= lnk.mem_wdata;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      rdata_q <= UTD_NULL;
    end
    else
    begin
      ack_q <= lnk.mem_req;
      rdata_q <= mem_q[ln_idx];
    end
  end

  // head or completion pointer writes are forwarded to the engine
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_wr_q <= 1'b0;
      reg_sel_q <= 1'b0;
      reg_wdata_q <= UTD_NULL;
    end
    else
    begin
      reg_wr_q <= sw_wr && (sw_addr == UTD_ADR_HEAD || sw_addr == UTD_ADR_COMP);
      reg_sel_q <= (sw_addr == UTD_ADR_COMP);
      reg_wdata_q <= sw_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sw_rdata <= UTD_NULL;
    else if (sw_rd)
    begin
      if (sw_addr == UTD_ADR_HEAD)
        sw_rdata <= lnk.tx_queue_head_ptr;
      else if (sw_addr == UTD_ADR_COMP)
        sw_rdata <= lnk.tx_completion_ptr;
      else if (sw_addr == UTD_ADR_STAT)
        sw_rdata <= {31'h0000_0000, lnk.chan_irq};
      else if (sw_addr < UTD_ADR_MEM_TOP)
        sw_rdata <= mem_q[sw_idx];
      else
        sw_rdata <= UTD_NULL;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ep_valid <= 1'b0;
      ep_data <= 8'h00;
      ep_last <= 1'b0;
      ep_zero <= 1'b0;
    end
    else if (lnk.tx_valid && !ep_valid)
    begin
      ep_valid <= 1'b1;
      ep_data <= lnk.tx_data;
      ep_last <= lnk.tx_last;
      ep_zero <= lnk.tx_zero;
    end
    else if (ep_take)
      ep_valid <= 1'b0;
  end
endmodule // utd_partner
`default_nettype wire

// >>> rtl/utd_engine.sv
// transmit dma engine walking a linked descriptor queue for one channel
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - bit 31 marks packet's first buffer
// - bit 30 marks packet's last buffer
// - first and last together: one-buffer packet
// - ownership bit read only on first descriptor
// - engine clears ownership after packet done
// - engine sets drained flag on final descriptor
// - zero-byte flag: no data, empty packet
// - software sets length one with zero-byte
// - length bits 15:0 taken from first only
// - stop at programmed length, truncate rest
// - software keeps length within buffer sum
// - middle buffers carry neither flag
// - keep head, completion, pointers and lengths
// - one queue with head and completion
// - software appends tail, engine frees head
// - walk descriptors in link order
// - 16-byte descriptors, zero link ends queue
// - nonzero head write starts until empty
// - queue end: release, flag, zero head, complete
// - interrupt drops when acknowledge matches
module utd_engine
  import utd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  utd_if.engine lnk,
  output logic busy,
  output logic [15:0] tx_packet_length_state,
  output logic [31:0] tx_current_desc_ptr
);
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_FETCH = 10'h002, S_FWAIT = 10'h004, S_DECODE = 10'h008,
    S_RD = 10'h010, S_RWAIT = 10'h020, S_SEND = 10'h040, S_ZERO = 10'h080,
    S_WR = 10'h100, S_WWAIT = 10'h200
  } utd_state_t;

  utd_state_t st_q;
  logic [31:0] head_q, comp_q, first_q, cur_q, buf_q, next_q, wr_addr_q, wr_data_q;
  logic [31:0] w3_q, first_ctl_q;
  logic [15:0] rem_q, act_q, buf_rem_q;
  logic [1:0] widx_q;
  logic irq_q, zero_q, drain_pend_q, fin_pend_q;
  logic [7:0] byte_q;
  logic req_q, we_q;
  logic [31:0] addr_q;
  logic [31:0] ctl;
  logic is_first, is_last;
  logic done_ev;
  logic send_done;

  // only the defined control fields are looked at
  assign ctl = lnk.mem_rdata & UTD_CTL_MASK;
  assign is_first = w3_q[UTD_FIRST_BIT];
  assign is_last = w3_q[UTD_LAST_BIT];
  assign done_ev = (st_q == S_WWAIT) && lnk.mem_ack && fin_pend_q && !drain_pend_q;
  assign send_done = zero_q || (rem_q == 16'h0000) || (buf_rem_q == 16'h0000);

  assign lnk.mem_req = req_q;
  assign lnk.mem_we = we_q;
  assign lnk.mem_addr = addr_q;
  assign lnk.mem_wdata = wr_data_q;
  assign lnk.tx_queue_head_ptr = head_q;
  assign lnk.tx_completion_ptr = comp_q;
  assign lnk.chan_irq = irq_q;
  assign lnk.tx_data = byte_q;
  // no stale beat while a finished buffer hands over to the next descriptor
  assign lnk.tx_valid = ((st_q == S_SEND) && !send_done) || (st_q == S_ZERO);
  assign lnk.tx_zero = (st_q == S_ZERO);
  assign lnk.tx_last = (st_q == S_ZERO) || (rem_q == 16'h0001);

  // sequencer and per-channel transfer state
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= S_IDLE;
      head_q <= UTD_NULL;
      comp_q <= UTD_NULL;
      first_q <= UTD_NULL;
      cur_q <= UTD_NULL;
      buf_q <= UTD_NULL;
      next_q <= UTD_NULL;
      w3_q <= UTD_NULL;
      first_ctl_q <= UTD_NULL;
      wr_addr_q <= UTD_NULL;
      wr_data_q <= UTD_NULL;
      rem_q <= 16'h0000;
      act_q <= 16'h0000;
      buf_rem_q <= 16'h0000;
      widx_q <= 2'h0;
      zero_q <= 1'b0;
      drain_pend_q <= 1'b0;
      fin_pend_q <= 1'b0;
      byte_q <= 8'h00;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= UTD_NULL;
    end
    else
    begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      // software completion writes only acknowledge; the pointer keeps the engine's value
      case (st_q)
        S_IDLE:
        begin
          // head writes while busy are ignored; the engine owns the pointer then
          if (lnk.reg_wr && !lnk.reg_sel_comp)
            head_q <= lnk.reg_wdata;
          else if (head_q != UTD_NULL)
          begin
            cur_q <= head_q;
            widx_q <= 2'h0;
            st_q <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          req_q <= 1'b1;
          addr_q <= cur_q + {28'h000_0000, widx_q, 2'h0};
          st_q <= S_FWAIT;
        end
        S_FWAIT:
        begin
          if (lnk.mem_ack)
          begin
            case (widx_q)
              2'h0: next_q <= lnk.mem_rdata;
              2'h1: buf_q <= lnk.mem_rdata;
              2'h2: buf_rem_q <= lnk.mem_rdata[UTD_LW-1:0];
              default: w3_q <= ctl;
            endcase
            if (widx_q == 2'h2)
              wr_data_q <= lnk.mem_rdata; // keeps the offset until decode
            widx_q <= widx_q + 2'h1;
            st_q <= (widx_q == UTD_LAST_WORD) ? S_DECODE : S_FETCH;
          end
        end
        S_DECODE:
        begin
          if (is_first)
          begin
            first_q <= cur_q;
            first_ctl_q <= w3_q;
            rem_q <= w3_q[UTD_LW-1:0];
            act_q <= 16'h0000;
            zero_q <= w3_q[UTD_ZERO_BIT];
            buf_q <= buf_q + {16'h0000, wr_data_q[31:UTD_OFS_LSB]};
          end
          if (is_first && !w3_q[UTD_OWN_BIT])
          begin
            head_q <= UTD_NULL;
            st_q <= S_IDLE;
          end
          else if (is_first && w3_q[UTD_ZERO_BIT])
            st_q <= S_ZERO;
          else if (!is_first && send_done)
            st_q <= S_SEND;
          else
            st_q <= S_RD;
        end
        S_RD:
        begin
          req_q <= 1'b1;
          addr_q <= {buf_q[31:2], 2'h0};
          st_q <= S_RWAIT;
        end
        S_RWAIT:
        begin
          if (lnk.mem_ack)
          begin
            byte_q <= lnk.mem_rdata[8*buf_q[1:0] +: 8];
            st_q <= S_SEND;
          end
        end
        S_ZERO:
        begin
          if (lnk.tx_ready)
          begin
            rem_q <= 16'h0000;
            buf_rem_q <= 16'h0000;
            st_q <= S_SEND;
          end
        end
        S_SEND:
        begin
          // no data left for this buffer or packet: write back on the last buffer, zero head and stop on a zero link, else move on to the next descriptor
          if (send_done)
          begin
            if (is_last)
            begin
              wr_addr_q <= first_q + UTD_W3_OFF;
              wr_data_q <= first_ctl_q & ~(32'h1 << UTD_OWN_BIT);
              fin_pend_q <= 1'b1;
              drain_pend_q <= (next_q == UTD_NULL);
              st_q <= S_WR;
            end
            else if (next_q == UTD_NULL)
            begin
              head_q <= UTD_NULL;
              st_q <= S_IDLE;
            end
            else
            begin
              cur_q <= next_q;
              widx_q <= 2'h0;
              st_q <= S_FETCH;
            end
          end
          else if (lnk.tx_ready)
          begin
            buf_q <= buf_q + 32'h0000_0001;
            rem_q <= rem_q - 16'h0001;
            act_q <= act_q + 16'h0001;
            buf_rem_q <= buf_rem_q - 16'h0001;
            if (rem_q != 16'h0001 && buf_rem_q != 16'h0001)
              st_q <= S_RD;
            else
              buf_rem_q <= 16'h0000;
          end
        end
        S_WR:
        begin
          req_q <= 1'b1;
          we_q <= 1'b1;
          addr_q <= wr_addr_q;
          st_q <= S_WWAIT;
        end
        S_WWAIT:
        begin
          if (lnk.mem_ack)
          begin
            if (drain_pend_q)
            begin
              // the drained flag goes into the last descriptor after ownership is returned
              drain_pend_q <= 1'b0;
              wr_addr_q <= cur_q + UTD_W3_OFF;
              wr_data_q <= (cur_q == first_q) ? (first_ctl_q & ~(32'h1 << UTD_OWN_BIT)) | (32'h1 << UTD_DRAIN_BIT)
                : w3_q | (32'h1 << UTD_DRAIN_BIT);
              st_q <= S_WR;
            end
            else
            begin
              fin_pend_q <= 1'b0;
              comp_q <= cur_q;
              head_q <= next_q;
              zero_q <= 1'b0;
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // interrupt: a completion in the same cycle as a matching acknowledge keeps it raised
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else if (done_ev)
      irq_q <= 1'b1;
    else if (lnk.reg_wr && lnk.reg_sel_comp && lnk.reg_wdata == comp_q)
      irq_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      tx_packet_length_state <= 16'h0000;
      tx_current_desc_ptr <= UTD_NULL;
    end
    else
    begin
      busy <= (st_q != S_IDLE);
      tx_packet_length_state <= act_q;
      tx_current_desc_ptr <= cur_q;
    end
  end
endmodule // utd_engine
`default_nettype wire

// >>> test/utd_monitor.sv
// link checker for the dma engine and its partner
`timescale 1ns/100ps
`default_nettype none
module utd_monitor
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic reg_wr,
  input wire logic reg_sel_comp,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] tx_queue_head_ptr,
  input wire logic [31:0] tx_completion_ptr,
  input wire logic chan_irq,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_zero,
  input wire logic tx_ready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  chk_ack_next: assert property (mem_req |=> mem_ack && !mem_req)
    else $error("memory handshake broken");
  chk_wr_word3: assert property (mem_req && mem_we |-> mem_addr[3:0] == 4'hC)
    else $error("write outside control word");
  chk_own_clear: assert property (mem_req && mem_we |-> !mem_wdata[29])
    else $error("ownership left set");
  chk_irq_cause: assert property ($rose(chan_irq) |-> tx_completion_ptr[3:0] == 4'h0 && tx_completion_ptr != 0)
    else $error("irq without completion");
  chk_ack_match: assert property (chan_irq && reg_wr && reg_sel_comp && reg_wdata == tx_completion_ptr |=> !chan_irq)
    else $error("irq kept after match");
  chk_ack_miss: assert property (chan_irq && reg_wr && reg_sel_comp && reg_wdata != tx_completion_ptr |=> chan_irq)
    else $error("irq dropped on mismatch");
  chk_zero_beat: assert property (tx_valid && tx_zero |-> tx_last)
    else $error("empty packet not last");
  chk_stream_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("byte changed while stalled");
  chk_drain_head: assert property (mem_req && mem_we && mem_wdata[28] |-> ##[1:8] tx_queue_head_ptr == 0)
    else $error("head not zeroed");
  chk_head_start: assert property (reg_wr && !reg_sel_comp && reg_wdata != 0 && tx_queue_head_ptr == 0 |-> ##[1:4] mem_req)
    else $error("start not taken");
  cov_zero: cover property (tx_valid && tx_ready && tx_zero);
  cov_irq: cover property ($rose(chan_irq));
  cov_drain: cover property (mem_req && mem_we && mem_wdata[28]);
endmodule // utd_monitor
`default_nettype wire

// >>> test/utd_tb.sv
// bench driving software port and endpoint sink around both ends
`timescale 1ns/100ps
`default_nettype none
module tb
  import utd_pkg::*;
;
  logic clock;
  logic rst_b;
  logic [31:0] sw_addr;
  logic [31:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [31:0] sw_rdata;
  logic ep_valid;
  logic [7:0] ep_data;
  logic ep_last;
  logic ep_zero;
  logic ep_take;
  logic busy;
  logic [31:0] rd;
  logic [15:0] pkt_len;
  logic [31:0] cur_desc;
  int fail_count;
  int total_checks;
  utd_if lnk();
  utd_engine utd_engine_i (.clock(clock), .rst_b(rst_b), .lnk(lnk), .busy(busy),
    .tx_packet_length_state(pkt_len), .tx_current_desc_ptr(cur_desc));
  utd_partner utd_partner_i (.clock(clock), .rst_b(rst_b), .lnk(lnk), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ep_valid(ep_valid), .ep_data(ep_data),
    .ep_last(ep_last), .ep_zero(ep_zero), .ep_take(ep_take));
  utd_monitor utd_monitor_i (.clock(clock), .rst_b(rst_b), .mem_req(lnk.mem_req), .mem_we(lnk.mem_we),
    .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata), .mem_ack(lnk.mem_ack), .reg_wr(lnk.reg_wr),
    .reg_sel_comp(lnk.reg_sel_comp), .reg_wdata(lnk.reg_wdata), .tx_queue_head_ptr(lnk.tx_queue_head_ptr),
    .tx_completion_ptr(lnk.tx_completion_ptr), .chan_irq(lnk.chan_irq), .tx_valid(lnk.tx_valid),
    .tx_data(lnk.tx_data), .tx_last(lnk.tx_last), .tx_zero(lnk.tx_zero), .tx_ready(lnk.tx_ready));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask
  // read data stands only after the strobe edge, so sample 1 ns later
  task automatic rdw(input logic [31:0] a);
    @(posedge clock);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 rd = sw_rdata;
  endtask
  task automatic desc(input logic [31:0] a, nx, bp, w2, w3);
    wr(a, nx);
    wr(a + 32'h4, bp);
    wr(a + 32'h8, w2);
    wr(a + 32'hC, w3);
  endtask
  task automatic take(input logic [7:0] d, input logic l, input logic z);
    int n;
    n = 0;
    @(posedge clock);
    while (ep_valid !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      $display("[ERR] %0t byte timeout", $time);
      complete_run();
    end
    check({z ? 8'h00 : ep_data, ep_last, ep_zero}, {d, l, z}, "byte");
    ep_take <= 1'b1;
    @(posedge clock);
    ep_take <= 1'b0;
  endtask
  // waits for this completion, not an earlier packet's interrupt
  task automatic wait_irq(input logic [31:0] a);
    int n;
    for (n = 0; n < 300 && !(lnk.chan_irq === 1'b1 && lnk.tx_completion_ptr === a); n++)
      @(posedge clock);
    check({31'h0, lnk.chan_irq}, 32'h1, "irq");
    if (n >= 300)
    begin
      fail_count++;
      $display("[ERR] %0t completion timeout", $time);
      complete_run();
    end
  endtask
  task automatic ack(input logic [31:0] a);
    wr(UTD_ADR_COMP, a);
    rdw(UTD_ADR_STAT);
    check(rd & 32'h1, 32'h0, "irq after ack");
  endtask
  // one buffer, reserved bits set, length shorter than buffer
  task automatic sc_single;
    wr(32'h0000_0200, 32'h4433_2211);
    desc(32'h0000_0100, UTD_NULL, 32'h0000_0200, 32'h0000_0004, 32'hE77F_0003);
    wr(UTD_ADR_HEAD, 32'h0000_0100);
    take(8'h11, 1'b0, 1'b0);
    take(8'h22, 1'b0, 1'b0);
    take(8'h33, 1'b1, 1'b0);
    wait_irq(32'h0000_0100);
    check({31'h0, ep_valid}, 32'h0, "byte past length");
    rdw(32'h0000_010C);
    check(rd & 32'h3000_0000, 32'h1000_0000, "own and drained");
    rdw(UTD_ADR_HEAD);
    check(rd, UTD_NULL, "head");
    rdw(UTD_ADR_COMP);
    check(rd, 32'h0000_0100, "completion");
    wr(UTD_ADR_COMP, 32'h0000_0110);
    rdw(UTD_ADR_STAT);
    check(rd & 32'h1, 32'h1, "irq kept");
    ack(32'h0000_0100);
  endtask
  // first, middle and last buffer walked in link order
  task automatic sc_multi;
    wr(32'h0000_0200, 32'h0000_00AA);
    wr(32'h0000_0204, 32'h0000_00BB);
    wr(32'h0000_0208, 32'h0000_00CC);
    desc(32'h0000_0100, 32'h0000_0110, 32'h0000_0200, 32'h0000_0001, 32'hA000_0003);
    desc(32'h0000_0110, 32'h0000_0120, 32'h0000_0204, 32'h0000_0001, 32'h0000_0000);
    desc(32'h0000_0120, UTD_NULL, 32'h0000_0208, 32'h0000_0001, 32'h4000_0000);
    wr(UTD_ADR_HEAD, 32'h0000_0100);
    take(8'hAA, 1'b0, 1'b0);
    take(8'hBB, 1'b0, 1'b0);
    take(8'hCC, 1'b1, 1'b0);
    wait_irq(32'h0000_0120);
    rdw(32'h0000_010C);
    check(rd & 32'h3000_0000, 32'h0, "first desc");
    rdw(32'h0000_012C);
    check(rd & 32'h1000_0000, 32'h1000_0000, "last desc");
    rdw(UTD_ADR_COMP);
    check(rd, 32'h0000_0120, "completion");
    check({busy, 15'h0000, pkt_len}, {1'b0, 15'h0000, 16'h0003}, "length state");
    check(cur_desc, 32'h0000_0120, "current desc");
    ack(32'h0000_0120);
  endtask
  // empty packet followed by a one byte packet
  task automatic sc_zero;
    wr(32'h0000_0200, 32'h0000_005A);
    desc(32'h0000_0100, 32'h0000_0110, 32'h0000_0200, 32'h0000_0001, 32'hE080_0001);
    desc(32'h0000_0110, UTD_NULL, 32'h0000_0200, 32'h0000_0001, 32'hE000_0001);
    wr(UTD_ADR_HEAD, 32'h0000_0100);
    take(8'h00, 1'b1, 1'b1);
    take(8'h5A, 1'b1, 1'b0);
    wait_irq(32'h0000_0110);
    rdw(32'h0000_010C);
    check(rd & 32'h3000_0000, 32'h0, "more queued");
    rdw(32'h0000_011C);
    check(rd & 32'h3000_0000, 32'h1000_0000, "queue end");
    ack(32'h0000_0110);
  endtask
  // host owned first descriptor halts without sending
  task automatic sc_unowned;
    desc(32'h0000_0100, UTD_NULL, 32'h0000_0200, 32'h0000_0001, 32'hC000_0001);
    wr(UTD_ADR_HEAD, 32'h0000_0100);
    repeat (40) @(posedge clock);
    check({30'h0, ep_valid, lnk.chan_irq}, 32'h0, "unowned sent");
    rdw(UTD_ADR_HEAD);
    check(rd, UTD_NULL, "head after halt");
  endtask
  initial
  begin
    rst_b = 1'b0;
    sw_addr = '0;
    sw_wdata = '0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    ep_take = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    sc_single();
    sc_multi();
    sc_zero();
    sc_unowned();
    complete_run();
  end
endmodule // tb
`default_nettype wire
